// ### logic/pcicfg_defines.vh
/*
 pcicfg_defines.vh: offsets, field positions, reset values and fixed codes of the
 configuration register bank. Holds definitions only; included by its bare name.
*/
`ifndef PCICFG_DEFINES_VH
`define PCICFG_DEFINES_VH

// bus geometry
`define PCICFG_AW            9
`define PCICFG_RESP_OKAY     2'b00

// register byte offsets
`define PCICFG_OFF_IDENT     9'h000
`define PCICFG_OFF_CMDSTAT   9'h004
`define PCICFG_OFF_CLASS     9'h008
`define PCICFG_OFF_LATCL     9'h00c
`define PCICFG_OFF_IOBASE    9'h010
`define PCICFG_OFF_MEMBASE   9'h014
`define PCICFG_OFF_SUBSYS    9'h02c
`define PCICFG_OFF_ROMBASE   9'h030
`define PCICFG_OFF_CAPPTR    9'h034
`define PCICFG_OFF_INTPAR    9'h03c
`define PCICFG_OFF_DRVSCR    9'h040
`define PCICFG_OFF_SIG       9'h080
`define PCICFG_OFF_PMCAP     9'h0c0
`define PCICFG_OFF_PMCSR     9'h0c4
`define PCICFG_OFF_IRQSTAT   9'h100
`define PCICFG_OFF_IRQCLR    9'h104
`define PCICFG_OFF_IRQEN     9'h108

// command word bits and reset values
`define PCICFG_CMD_IO        0
`define PCICFG_CMD_MEM       1
`define PCICFG_CMD_MASTER    2
`define PCICFG_CMD_PARRESP   6
`define PCICFG_CMD_SERREN    8
`define PCICFG_CMD_RST_IO    1'b1
`define PCICFG_CMD_RST_MEM   1'b1
`define PCICFG_CMD_RST_MST   1'b1
`define PCICFG_CMD_RST_PAR   1'b0
`define PCICFG_CMD_RST_SERR  1'b1

// status flags: index into the sticky flag vector and the interrupt registers
`define PCICFG_NFLAG         5
`define PCICFG_FL_DPR        0
`define PCICFG_FL_TAB        1
`define PCICFG_FL_MAB        2
`define PCICFG_FL_SERR       3
`define PCICFG_FL_PERR       4
`define PCICFG_STAT_NEWCAP   20
`define PCICFG_STAT_FBB      23
`define PCICFG_DEVSEL_MEDIUM 2'b01

// fixed read values
`define PCICFG_CLASS_VAL     32'h020000a0
`define PCICFG_CAPPTR_VAL    8'hc0
`define PCICFG_INTPIN_VAL    8'h01
`define PCICFG_PMCAP_VAL     32'h00020001
`define PCICFG_IO_IND        1'b1

// decode widths of the base registers
`define PCICFG_IO_LSB        7
`define PCICFG_MEM_LSB       7
`define PCICFG_ROM_LSB       14
`define PCICFG_ROM_EN        0

`endif

// ### logic/pcicfg_sticky.v
/*
 pcicfg_sticky.v: a vector of sticky flags, set by hardware, cleared per bit.
 Assumes set and clear are synchronous one-cycle or level terms of clk_in.
*/
`timescale 1ns/10ps
module pcicfg_sticky #(
	parameter WIDTH = 1
) (
	input  wire             clk_in,   // system clock
	input  wire             reset_in, // async reset, active high
	input  wire [WIDTH-1:0] set_in,   // per-bit set
	input  wire [WIDTH-1:0] clr_in,   // per-bit clear
	output reg  [WIDTH-1:0] flag_out  // sticky flags
);

	// set beats clear so an event in the clearing cycle is kept
	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			flag_out <= {WIDTH{1'b0}};
		else
			flag_out <= set_in | (flag_out & ~clr_in);
	end

endmodule

// ### logic/pcicfg_regs.v
/*
 pcicfg_regs.v: configuration register bank of a bus-master network controller,
 reached over an AXI4-Lite slave, with identity values fetched from a serial
 memory loader after reset and sticky error status with a level interrupt.
 Assumes all inputs are synchronous to clk_in and that the loader and the bus
 interface logic present their events as one-cycle pulses or levels.
*/
// Our own choice: the AXI4-Lite register port.
// Functional notes
// - hardware reset loads every configuration register with its default
// - controller software reset leaves configuration contents untouched
// - byte, halfword and word accesses touch only the enabled byte lanes
// - identity word: device id high half, vendor id low, both read-only
// - after reset release, fetch ids, subsystem ids, max latency, min grant
// - driver scratch bits 15:8 read back as written, rest reserved
// - signature register returns a fixed value and ignores writes
// - parity error flag sets on any detected parity error
// - system error flag sets whenever the system error output is driven
// - master abort flag sets when own master cycle ends in master abort
// - target abort flag sets when a target aborts an own master cycle
// - devsel timing field reads medium and targets claim with medium timing
// - data parity flag needs perr, bus mastership and parity response enabled
// - fast back-to-back flag reads one and target accepts such cycles
// - boot rom base decodes a window sized for a 128 kilobit rom
// - parity response enable resets to zero; when set together with serr enable, parity errors raise serr
`timescale 1ns/10ps
`include "pcicfg_defines.vh"
module pcicfg_regs #(
	parameter [31:0] SIGNATURE = 32'h5a5a1234 // arbitrary fixed signature value
) (
	input  wire                   clk_in,          // system clock, 125 mhz
	input  wire                   reset_in,        // hardware reset, async, high
	input  wire                   soft_reset_in,   // controller software reset
	// axi4-lite slave
	input  wire [`PCICFG_AW-1:0]  s_axi_awaddr,    // write address
	input  wire                   s_axi_awvalid,   // write address valid
	output wire                   s_axi_awready,   // write address ready
	input  wire [31:0]            s_axi_wdata,     // write data
	input  wire [3:0]             s_axi_wstrb,     // write byte strobes
	input  wire                   s_axi_wvalid,    // write data valid
	output wire                   s_axi_wready,    // write data ready
	output wire [1:0]             s_axi_bresp,     // write response
	output reg                    s_axi_bvalid,    // write response valid
	input  wire                   s_axi_bready,    // write response ready
	input  wire [`PCICFG_AW-1:0]  s_axi_araddr,    // read address
	input  wire                   s_axi_arvalid,   // read address valid
	output wire                   s_axi_arready,   // read address ready
	output reg  [31:0]            s_axi_rdata,     // read data
	output wire [1:0]             s_axi_rresp,     // read response
	output reg                    s_axi_rvalid,    // read data valid
	input  wire                   s_axi_rready,    // read data ready
	// serial memory loader
	output reg                    ee_fetch_req_out,  // fetch pending after reset
	input  wire                   ee_valid_in,       // loaded values present
	input  wire [15:0]            ee_device_id_in,   // loaded device identifier
	input  wire [15:0]            ee_vendor_id_in,   // loaded vendor identifier
	input  wire [15:0]            ee_subsys_id_in,   // subsystem id
	input  wire [15:0]            ee_subsys_ven_in,  // subsystem vendor id
	input  wire [7:0]             ee_min_gnt_in,     // minimum grant
	input  wire [7:0]             ee_max_lat_in,     // maximum latency
	input  wire                   ee_new_cap_in,     // capability list present
	// bus interface events
	input  wire                   parity_err_in,     // parity error detected
	input  wire                   perr_driven_in,    // device drove perr
	input  wire                   perr_seen_in,      // another agent drove perr
	input  wire                   bus_master_in,     // device is bus master
	input  wire                   master_abort_in,   // own cycle master-aborted
	input  wire                   target_abort_in,   // own cycle target-aborted
	input  wire [31:0]            rom_addr_in,       // address to check for rom
	output reg                    serr_assert_out,   // drive system error, pulse
	output wire [1:0]             devsel_timing_out, // devsel decode speed
	output wire                   fast_b2b_accept_out, // accept fast b2b cycles
	output wire                   io_enable_out,     // io space enable
	output wire                   mem_enable_out,    // memory space enable
	output wire                   master_enable_out, // bus master enable
	output wire                   rom_hit_out,       // rom window decode hit
	output wire                   irq_out            // level interrupt
);

	// configuration state
	reg  [15:0] device_id_r;
	reg  [15:0] vendor_id_r;
	reg  [15:0] subsys_id_r;
	reg  [15:0] subsys_ven_r;
	reg  [7:0]  min_gnt_r;
	reg  [7:0]  max_lat_r;
	reg         new_cap_r;
	reg  [8:0]  cmd_r;
	reg  [15:0] latcl_r;
	reg  [31:0] io_base_r;
	reg  [31:0] mem_base_r;
	reg  [31:0] rom_base_r;
	reg  [7:0]  int_line_r;
	reg  [7:0]  drv_scratch_r;
	reg  [1:0]  pm_state_r;
	reg  [`PCICFG_NFLAG-1:0] irq_en_r;

	// write channel holding
	reg                  aw_full_r;
	reg                  w_full_r;
	reg  [`PCICFG_AW-1:0] waddr_r;
	reg  [31:0]          wdata_r;
	reg  [3:0]           wstrb_r;
	wire                 do_write;
	wire [31:0]          bmask;
	reg  [31:0]          rd_word;

	// sticky flags
	wire [`PCICFG_NFLAG-1:0] err_set;
	wire [`PCICFG_NFLAG-1:0] err_clr;
	wire [`PCICFG_NFLAG-1:0] err_flags;
	wire [`PCICFG_NFLAG-1:0] irq_clr;
	wire [`PCICFG_NFLAG-1:0] irq_stat;
	wire [7:0]               stat_hi;

	// bit mask from byte strobes so only addressed lanes change
	assign bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [31:0] m;
		begin
			merge = (old_v & ~m) | (new_v & m);
		end
	endfunction

	// address and data are taken in either order; the response follows both
	assign s_axi_awready = ~aw_full_r;
	assign s_axi_wready  = ~w_full_r;
	assign s_axi_bresp   = `PCICFG_RESP_OKAY;
	assign do_write      = aw_full_r & w_full_r & ~s_axi_bvalid;

	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			aw_full_r    <= 1'b0;
			w_full_r     <= 1'b0;
			waddr_r      <= {`PCICFG_AW{1'b0}};
			wdata_r      <= 32'h00000000;
			wstrb_r      <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_full_r)
			begin
				aw_full_r <= 1'b1;
				waddr_r   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r)
			begin
				w_full_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_full_r    <= 1'b0;
				w_full_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// identity fetch: pending from reset until the loader delivers once
	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ee_fetch_req_out <= 1'b1;
			device_id_r      <= 16'h0000;
			vendor_id_r      <= 16'h0000;
			subsys_id_r      <= 16'h0000;
			subsys_ven_r     <= 16'h0000;
			min_gnt_r        <= 8'h00;
			max_lat_r        <= 8'h00;
			new_cap_r        <= 1'b0;
		end
		else if (ee_fetch_req_out && ee_valid_in)
		begin
			ee_fetch_req_out <= 1'b0;
			device_id_r      <= ee_device_id_in;
			vendor_id_r      <= ee_vendor_id_in;
			subsys_id_r      <= ee_subsys_id_in;
			subsys_ven_r     <= ee_subsys_ven_in;
			min_gnt_r        <= ee_min_gnt_in;
			max_lat_r        <= ee_max_lat_in;
			new_cap_r        <= ee_new_cap_in;
		end
	end

	// writable fields; soft_reset_in is deliberately not an input here so a
	// controller reset cannot disturb the configuration
	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			cmd_r <= 9'h000;
			cmd_r[`PCICFG_CMD_IO]      <= `PCICFG_CMD_RST_IO;
			cmd_r[`PCICFG_CMD_MEM]     <= `PCICFG_CMD_RST_MEM;
			cmd_r[`PCICFG_CMD_MASTER]  <= `PCICFG_CMD_RST_MST;
			cmd_r[`PCICFG_CMD_PARRESP] <= `PCICFG_CMD_RST_PAR;
			cmd_r[`PCICFG_CMD_SERREN]  <= `PCICFG_CMD_RST_SERR;
			latcl_r       <= 16'h0000;
			io_base_r     <= 32'h00000000;
			mem_base_r    <= 32'h00000000;
			rom_base_r    <= 32'h00000000;
			int_line_r    <= 8'h00;
			drv_scratch_r <= 8'h00;
			pm_state_r    <= 2'b00;
			irq_en_r      <= {`PCICFG_NFLAG{1'b0}};
		end
		else if (do_write)
		begin
			case (waddr_r)
			`PCICFG_OFF_CMDSTAT:
			begin
				// only implemented command bits take a write
				cmd_r[`PCICFG_CMD_IO]      <= wstrb_r[0] ? wdata_r[`PCICFG_CMD_IO]
				                                         : cmd_r[`PCICFG_CMD_IO];
				cmd_r[`PCICFG_CMD_MEM]     <= wstrb_r[0] ? wdata_r[`PCICFG_CMD_MEM]
				                                         : cmd_r[`PCICFG_CMD_MEM];
				cmd_r[`PCICFG_CMD_MASTER]  <= wstrb_r[0] ? wdata_r[`PCICFG_CMD_MASTER]
				                                         : cmd_r[`PCICFG_CMD_MASTER];
				cmd_r[`PCICFG_CMD_PARRESP] <= wstrb_r[0] ? wdata_r[`PCICFG_CMD_PARRESP]
				                                         : cmd_r[`PCICFG_CMD_PARRESP];
				cmd_r[`PCICFG_CMD_SERREN]  <= wstrb_r[1] ? wdata_r[`PCICFG_CMD_SERREN]
				                                         : cmd_r[`PCICFG_CMD_SERREN];
			end
			`PCICFG_OFF_LATCL:
				latcl_r <= {wstrb_r[1] ? wdata_r[15:8] : latcl_r[15:8],
				            wstrb_r[0] ? wdata_r[7:0] : latcl_r[7:0]};
			`PCICFG_OFF_IOBASE:
				io_base_r <= merge(io_base_r, wdata_r, bmask)
				             & ({32{1'b1}} << `PCICFG_IO_LSB);
			`PCICFG_OFF_MEMBASE:
				mem_base_r <= merge(mem_base_r, wdata_r, bmask)
				              & ({32{1'b1}} << `PCICFG_MEM_LSB);
			`PCICFG_OFF_ROMBASE:
				// low address bits are hard zero, which sizes the window
				rom_base_r <= merge(rom_base_r, wdata_r, bmask)
				              & (({32{1'b1}} << `PCICFG_ROM_LSB) | 32'h00000001);
			`PCICFG_OFF_INTPAR:
				int_line_r <= wstrb_r[0] ? wdata_r[7:0] : int_line_r;
			`PCICFG_OFF_DRVSCR:
				drv_scratch_r <= wstrb_r[1] ? wdata_r[15:8] : drv_scratch_r;
			`PCICFG_OFF_PMCSR:
				pm_state_r <= wstrb_r[0] ? wdata_r[1:0] : pm_state_r;
			`PCICFG_OFF_IRQEN:
				irq_en_r <= wstrb_r[0] ? wdata_r[`PCICFG_NFLAG-1:0] : irq_en_r;
			default:
				cmd_r <= cmd_r;
			endcase
		end
	end

	// a parity error raises system error only when both enables are on
	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			serr_assert_out <= 1'b0;
		else
			serr_assert_out <= parity_err_in & cmd_r[`PCICFG_CMD_PARRESP]
			                   & cmd_r[`PCICFG_CMD_SERREN];
	end

	// flag set terms, laid out as status byte three
	assign err_set[`PCICFG_FL_DPR]  = (perr_driven_in | perr_seen_in) & bus_master_in
	                                  & cmd_r[`PCICFG_CMD_PARRESP];
	assign err_set[`PCICFG_FL_TAB]  = target_abort_in;
	assign err_set[`PCICFG_FL_MAB]  = master_abort_in;
	assign err_set[`PCICFG_FL_SERR] = serr_assert_out;
	assign err_set[`PCICFG_FL_PERR] = parity_err_in;

	// write-one-to-clear over the status byte lane
	assign stat_hi = wdata_r[31:24] & {8{wstrb_r[3]}};
	assign err_clr = (do_write && waddr_r == `PCICFG_OFF_CMDSTAT)
	                 ? {stat_hi[7:4], stat_hi[0]} : {`PCICFG_NFLAG{1'b0}};
	assign irq_clr = (do_write && waddr_r == `PCICFG_OFF_IRQCLR && wstrb_r[0])
	                 ? wdata_r[`PCICFG_NFLAG-1:0] : {`PCICFG_NFLAG{1'b0}};

	pcicfg_sticky #(
		.WIDTH (`PCICFG_NFLAG)
	) u_err_flags (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.set_in   (err_set),
		.clr_in   (err_clr),
		.flag_out (err_flags)
	);

	pcicfg_sticky #(
		.WIDTH (`PCICFG_NFLAG)
	) u_irq_flags (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.set_in   (err_set),
		.clr_in   (irq_clr),
		.flag_out (irq_stat)
	);

	assign irq_out = |(irq_stat & irq_en_r);

	// read decode; unmapped words read zero
	always @*
	begin
		rd_word = 32'h00000000;
		case (s_axi_araddr)
		`PCICFG_OFF_IDENT:   rd_word = {device_id_r, vendor_id_r};
		`PCICFG_OFF_CMDSTAT:
		begin
			rd_word = {23'h000000, cmd_r};
			rd_word[31:28] = err_flags[4:1];
			rd_word[26:25] = `PCICFG_DEVSEL_MEDIUM;
			rd_word[24]    = err_flags[0];
			rd_word[`PCICFG_STAT_FBB]    = 1'b1;
			rd_word[`PCICFG_STAT_NEWCAP] = new_cap_r;
		end
		`PCICFG_OFF_CLASS:   rd_word = `PCICFG_CLASS_VAL;
		`PCICFG_OFF_LATCL:   rd_word = {16'h0000, latcl_r};
		`PCICFG_OFF_IOBASE:  rd_word = io_base_r | {31'h0, `PCICFG_IO_IND};
		`PCICFG_OFF_MEMBASE: rd_word = mem_base_r;
		`PCICFG_OFF_SUBSYS:  rd_word = {subsys_id_r, subsys_ven_r};
		`PCICFG_OFF_ROMBASE: rd_word = rom_base_r;
		`PCICFG_OFF_CAPPTR:  rd_word = {24'h000000, `PCICFG_CAPPTR_VAL};
		`PCICFG_OFF_INTPAR:  rd_word = {max_lat_r, min_gnt_r, `PCICFG_INTPIN_VAL, int_line_r};
		`PCICFG_OFF_DRVSCR:  rd_word = {16'h0000, drv_scratch_r, 8'h00};
		`PCICFG_OFF_SIG:     rd_word = SIGNATURE;
		`PCICFG_OFF_PMCAP:   rd_word = `PCICFG_PMCAP_VAL;
		`PCICFG_OFF_PMCSR:   rd_word = {30'h00000000, pm_state_r};
		`PCICFG_OFF_IRQSTAT: rd_word = {27'h0000000, irq_stat};
		`PCICFG_OFF_IRQEN:   rd_word = {27'h0000000, irq_en_r};
		default:             rd_word = 32'h00000000;
		endcase
	end

	// one read at a time; rdata registered when the address is taken
	assign s_axi_arready = ~s_axi_rvalid;
	assign s_axi_rresp   = `PCICFG_RESP_OKAY;

	always @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
		end
		else if (s_axi_arvalid && !s_axi_rvalid)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// target-side timing and enables
	assign devsel_timing_out   = `PCICFG_DEVSEL_MEDIUM;
	assign fast_b2b_accept_out = 1'b1;
	assign io_enable_out       = cmd_r[`PCICFG_CMD_IO];
	assign mem_enable_out      = cmd_r[`PCICFG_CMD_MEM];
	assign master_enable_out   = cmd_r[`PCICFG_CMD_MASTER];
	assign rom_hit_out = rom_base_r[`PCICFG_ROM_EN] & mem_enable_out
	                     & (rom_addr_in[31:`PCICFG_ROM_LSB]
	                        == rom_base_r[31:`PCICFG_ROM_LSB]);

endmodule

// ### verification/pcicfg_regs_sva.sv
/*
 pcicfg_regs_sva.sv: bus and status checks on the register bank ports.
 Assumes it is bound to pcicfg_regs and sees only that module's ports.
*/
`timescale 1ns/10ps
module pcicfg_chk (
	input logic       clk_in,              // clock
	input logic       reset_in,            // reset
	input logic       s_axi_arvalid,       // read request
	input logic       s_axi_arready,       // read accept
	input logic       s_axi_rvalid,        // read answer
	input logic       s_axi_rready,        // read taken
	input logic       s_axi_bvalid,        // write answer
	input logic       s_axi_bready,        // write taken
	input logic [1:0] s_axi_bresp,         // write code
	input logic [1:0] s_axi_rresp,         // read code
	input logic       ee_fetch_req_out,    // fetch pending
	input logic       ee_valid_in,         // loader valid
	input logic       parity_err_in,       // parity event
	input logic       serr_assert_out,     // system error
	input logic [1:0] devsel_timing_out,   // devsel code
	input logic       fast_b2b_accept_out, // b2b accept
	input logic       irq_out              // interrupt
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// bus answers: timing, holding and response code
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_resp_okay: assert property ((s_axi_bvalid |-> s_axi_bresp == 2'b00)
		and (s_axi_rvalid |-> s_axi_rresp == 2'b00)) else $error("response not okay");
	// fixed target timing codes
	a_devsel_medium: assert property (devsel_timing_out == 2'b01)
		else $error("devsel timing wrong");
	a_b2b_accept: assert property (fast_b2b_accept_out)
		else $error("fast b2b refused");
	// the fetch is one shot per reset and ends on the first valid
	a_fetch_ends: assert property (ee_fetch_req_out && ee_valid_in |=> !ee_fetch_req_out)
		else $error("fetch did not end");
	a_fetch_once: assert property (!ee_fetch_req_out |=> !ee_fetch_req_out)
		else $error("fetch restarted");
	// system error only ever follows a parity event by one cycle
	a_serr_cause: assert property (serr_assert_out |-> $past(parity_err_in))
		else $error("system error without parity");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_serr: cover property (serr_assert_out);
	c_irq: cover property (irq_out);
endmodule
bind pcicfg_regs pcicfg_chk i_chk (.clk_in, .reset_in, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rresp,
	.ee_fetch_req_out, .ee_valid_in, .parity_err_in, .serr_assert_out, .devsel_timing_out,
	.fast_b2b_accept_out, .irq_out);

// ### verification/pcicfg_loader_model.sv
/*
 pcicfg_loader_model.sv: behavioural serial memory loader that answers the
 bank's fetch request. Assumes one clock and the bank's hardware reset.
*/
`timescale 1ns/10ps
module pcicfg_loader_model #(
	parameter int          DLY = 5,                   // cycles until the image is ready
	parameter logic [63:0] IMG = 64'h1e2d3c4b5a697887, // arbitrary identifiers
	parameter logic [15:0] BUS = 16'h2814             // arbitrary latency and grant
) (
	input  logic        clk_in,    // clock
	input  logic        reset_in,  // reset
	input  logic        req_in,    // fetch request
	output logic        valid_out, // image valid
	output logic [63:0] img_out,   // identifiers
	output logic [15:0] bus_out    // latency, grant
);
	int cnt;
	// fetch latency counter, restarted whenever no request is pending
	always @(posedge clk_in or posedge reset_in)
		if (reset_in || !req_in)
			cnt <= 0;
		else if (cnt < DLY)
			cnt <= cnt + 1;
	assign valid_out = req_in && cnt == DLY;
	// outside the valid cycle the lines show the inverse, so a late capture shows up
	assign img_out = valid_out ? IMG : ~IMG;
	assign bus_out = valid_out ? BUS : ~BUS;
endmodule

// ### verification/test_pci_config_space_regs.sv
/*
 test_pci_config_space_regs.sv: self-checking bench of the register bank.
 Assumes the loader model and the bound checker beside the design.
*/
`timescale 1ns/10ps
module test_pci_config_space_regs;
	localparam logic [63:0] IMG = 64'h1e2d3c4b5a697887; // arbitrary identifiers
	localparam logic [15:0] BUS = 16'h2814;
	logic        clk_in = 0, reset_in = 1, soft_rst = 0;
	logic [8:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rom_addr = 0, rd_v, rdata;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, req, ee_valid, serr, rom_hit, irq;
	logic [1:0]  bresp, rresp, devsel;
	logic [2:0]  en; // io, memory, master enables
	logic [63:0] img;
	logic [15:0] bus;
	logic [5:0]  evv = 0; // parity, perr driven, perr seen, master, m-abort, t-abort
	int          mismatches = 0, n_compared = 0;
	pcicfg_regs i_dut (.clk_in(clk_in), .reset_in(reset_in), .soft_reset_in(soft_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ee_fetch_req_out(req), .ee_valid_in(ee_valid), .ee_device_id_in(img[63:48]),
		.ee_vendor_id_in(img[47:32]), .ee_subsys_id_in(img[31:16]),
		.ee_subsys_ven_in(img[15:0]), .ee_min_gnt_in(bus[7:0]), .ee_max_lat_in(bus[15:8]),
		.ee_new_cap_in(1'b1), .parity_err_in(evv[5]), .perr_driven_in(evv[4]),
		.perr_seen_in(evv[3]), .bus_master_in(evv[2]), .master_abort_in(evv[1]),
		.target_abort_in(evv[0]), .rom_addr_in(rom_addr), .serr_assert_out(serr),
		.devsel_timing_out(devsel), .fast_b2b_accept_out(), .io_enable_out(en[0]),
		.mem_enable_out(en[1]), .master_enable_out(en[2]), .rom_hit_out(rom_hit),
		.irq_out(irq));
	pcicfg_loader_model #(.IMG(IMG), .BUS(BUS)) i_ldr (.clk_in(clk_in), .reset_in(reset_in),
		.req_in(req), .valid_out(ee_valid), .img_out(img), .bus_out(bus));
	// free-running 125 mhz clock
	always #4 clk_in = ~clk_in;
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		begin
			n_compared++;
			if (got !== exp)
			begin
				mismatches++;
				$display("[ERR] %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// each channel is released at the edge that takes it; bready held until bvalid
	task wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s);
		begin
			@(posedge clk_in);
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
			repeat (64)
			begin
				@(posedge clk_in);
				if (awvalid && awready)
					awvalid <= 0;
				if (wvalid && wready)
					wvalid <= 0;
				if (bvalid)
					break;
			end
			bready <= 0;
			chk("write answer", 32'h1, {31'h0, bvalid});
		end
	endtask
	task rd(input logic [8:0] a, input logic [31:0] e);
		begin
			rd_v = 32'hx;
			@(posedge clk_in);
			araddr <= a;
			arvalid <= 1;
			rready <= 1;
			repeat (64)
			begin
				@(posedge clk_in);
				if (arvalid && arready)
					arvalid <= 0;
				if (rvalid)
				begin
					rd_v = rdata;
					break;
				end
			end
			rready <= 0;
			chk($sformatf("reg %h", a), e, rd_v);
		end
	endtask
	task ev(input logic [5:0] v);
		begin
			@(posedge clk_in);
			evv <= v;
			@(posedge clk_in);
			evv <= 0;
			repeat (3) @(posedge clk_in);
		end
	endtask
	task hw_reset;
		begin
			reset_in <= 1;
			repeat (20) @(posedge clk_in);
			reset_in <= 0;
			@(posedge clk_in);
			chk("fetch req", 32'h1, {31'h0, req});
			repeat (64)
			begin
				@(posedge clk_in);
				if (!req)
					break;
			end
			chk("fetch done", 32'h0, {31'h0, req});
		end
	endtask
	task report_and_stop;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// watchdog: the whole sequence needs well under a thousand accesses
	initial
	begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		report_and_stop();
	end
	initial
	begin
		hw_reset();
		rd(9'h000, IMG[63:32]);
		rd(9'h02c, IMG[31:0]);
		rd(9'h03c, {BUS, 16'h0100});
		rd(9'h004, 32'h02900107);
		wr(9'h000, 32'hffffffff, 4'hf);
		rd(9'h000, IMG[63:32]);
		wr(9'h080, 32'h0, 4'hf);
		rd(9'h080, 32'h5a5a1234);
		wr(9'h040, 32'hffffffff, 4'hf);
		rd(9'h040, 32'h0000ff00);
		wr(9'h018, 32'hffffffff, 4'hf);
		rd(9'h018, 32'h0);
		wr(9'h03c, 32'ha5a5a5a5, 4'h1);
		rd(9'h03c, {BUS, 16'h01a5});
		wr(9'h00c, 32'h12345678, 4'h3);
		wr(9'h00c, 32'h0000ab00, 4'h2);
		rd(9'h00c, 32'h0000ab78);
		ev(6'h02);
		rd(9'h004, 32'h22900107);
		ev(6'h01);
		rd(9'h004, 32'h32900107);
		ev(6'h34);
		rd(9'h004, 32'hb2900107);
		wr(9'h004, 32'h7f000000, 4'h8);
		rd(9'h004, 32'h82900107);
		wr(9'h004, 32'hff000047, 4'h9);
		rd(9'h004, 32'h02900147);
		ev(6'h0c);
		rd(9'h004, 32'h03900147);
		ev(6'h20);
		rd(9'h004, 32'hc3900147);
		chk("irq", 32'h0, {31'h0, irq});
		rd(9'h100, 32'h0000001f);
		wr(9'h108, 32'h4, 4'hf);
		chk("irq", 32'h1, {31'h0, irq});
		wr(9'h104, 32'h4, 4'hf);
		chk("irq", 32'h0, {31'h0, irq});
		rd(9'h100, 32'h0000001b);
		wr(9'h040, 32'h00005a00, 4'hf);
		soft_rst <= 1;
		@(posedge clk_in);
		soft_rst <= 0;
		rd(9'h040, 32'h00005a00);
		rd(9'h004, 32'hc3900147);
		wr(9'h030, 32'h00027fff, 4'hf);
		rd(9'h030, 32'h00024001);
		rom_addr <= 32'h00027ffc;
		repeat (2) @(posedge clk_in);
		chk("rom hit", 32'h1, {31'h0, rom_hit});
		rom_addr <= 32'h00028000;
		repeat (2) @(posedge clk_in);
		chk("rom hit", 32'h0, {31'h0, rom_hit});
		wr(9'h004, 32'h00000000, 4'h1);
		chk("enables", 32'h0, {29'h0, en});
		hw_reset();
		chk("enables", 32'h7, {29'h0, en});
		rd(9'h040, 32'h0);
		rd(9'h004, 32'h02900107);
		rd(9'h100, 32'h0);
		report_and_stop();
	end
endmodule
